// file: src/serial_port_pkg.sv
// constants, field positions and state encodings of the serial port
// assumes one 10 MHz system clock and a plain word-addressed register port
package serial_port_pkg;
  ////////////////////////////////////////////////////////////////////
  localparam logic [3:0] ADDR_TDR = 4'h0;
  localparam logic [3:0] ADDR_RDR = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam logic [3:0] ADDR_PCR = 4'h3;
  localparam logic [3:0] ADDR_SRG1 = 4'h4;
  localparam logic [3:0] ADDR_SRG2 = 4'h5;
  localparam logic [3:0] ADDR_STAT = 4'h6;
  localparam logic [3:0] ADDR_TXMASK = 4'h7;
  localparam logic [3:0] ADDR_RXMASK = 4'h8;
  ////////////////////////////////////////////////////////////////////
  // serial_pin_control fields
  localparam int PCR_TX_GPIO_ENABLE = 13;
  localparam int PCR_RX_GPIO_ENABLE = 12;
  localparam int PCR_TX_FRAME_SYNC_MODE = 11;
  localparam int PCR_RX_FRAME_SYNC_MODE = 10;
  localparam int PCR_TX_CLOCK_MODE = 9;
  localparam int PCR_RX_CLOCK_MODE = 8;
  localparam int PCR_SAMPLE_CLOCK_EXT_SELECT = 7;
  localparam int PCR_SAMPLE_CLOCK_PIN_STATE = 6;
  localparam int PCR_TX_DATA_PIN_STATE = 5;
  localparam int PCR_RX_DATA_PIN_STATE = 4;
  localparam int PCR_TX_FRAME_SYNC_POLARITY = 3;
  localparam int PCR_RX_FRAME_SYNC_POLARITY = 2;
  localparam int PCR_TX_CLOCK_POLARITY = 1;
  localparam int PCR_RX_CLOCK_POLARITY = 0;
  localparam logic [15:0] PCR_WMASK = 16'h3FFF;
  localparam logic [15:0] PCR_RST = 16'h0000;
  ////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int CTRL_W = 19;
  localparam int C_TX_EN = 0;
  localparam int C_RX_EN = 1;
  localparam int C_WLEN = 2;
  localparam int C_COMP = 5;
  localparam int C_ALAW = 6;
  localparam int C_MC = 7;
  localparam int C_CSTOP = 8;
  localparam int C_CSMASTER = 9;
  localparam int C_FDLY = 10;
  localparam int C_NWORDS = 12;
  localparam logic [CTRL_W-1:0] CTRL_RST = 19'h00000;
  // generator fields
  localparam int S_DIV = 0;
  localparam int S_FWID = 8;
  localparam int S_FPER = 0;
  localparam int S_EXT = 12;
  localparam int S_PINSEL = 13;
  // status fields
  localparam int ST_TXRDY = 0;
  localparam int ST_RXRDY = 1;
  localparam int ST_URUN = 2;
  localparam int ST_ORUN = 3;
  localparam int ST_RBRF = 4;
  ////////////////////////////////////////////////////////////////////
  localparam logic [2:0] WL_CODE_MAX = 3'h5;
  localparam logic [5:0] WORD_BITS [0:5] = '{6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h20};
  localparam logic [5:0] WL_COMP = 6'h08;
  localparam logic [5:0] WL_FULL = 6'h20;
  localparam logic [15:0] MU_BIAS = 16'h0084;
  localparam logic [15:0] MU_CLIP = 16'h7F7B;
  localparam logic [7:0] ALAW_XOR = 8'h55;
  localparam logic [15:0] ALAW_SEG = 16'h0100;
  localparam logic [15:0] ALAW_CLIP = 16'h7FFF;
  typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_DELAY = 2'b01, PH_SHIFT = 2'b11} phase_e;
endpackage : serial_port_pkg

// file: src/serial_port.sv
// multichannel serial port: data registers, shifters, clock and frame generator
// assumes pins already synchronous to I_CLK_SYS and a one-cycle register port
`timescale 1ns/100ps
`default_nettype none
module serial_port (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  // register port
  input wire logic [3:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  // transmit link
  input wire logic I_TX_CLK,
  output logic O_TX_CLK,
  output logic O_TX_CLK_OE,
  input wire logic I_TX_FS,
  output logic O_TX_FS,
  output logic O_TX_FS_OE,
  output logic O_TX_DATA,
  output logic O_TX_DATA_OE,
  // receive link
  input wire logic I_RX_CLK,
  output logic O_RX_CLK,
  output logic O_RX_CLK_OE,
  input wire logic I_RX_FS,
  output logic O_RX_FS,
  output logic O_RX_FS_OE,
  input wire logic I_RX_DATA,
  input wire logic I_SAMPLE_CLK,
  // transfer pacing events
  output logic O_TX_EVENT,
  output logic O_RX_EVENT
);
  import serial_port_pkg::*;
  typedef struct packed {
    logic [31:0] tdr, tsr, receive_buffer_reg, receive_shift_reg, rdr, rdata, txmask, rxmask;
    logic [15:0] serial_pin_control, srg1, srg2;
    logic [CTRL_W-1:0] ctrl;
    logic tdr_full, rbr_full, rdr_full, tx_urun, rx_orun;
    phase_e tx_ph, rx_ph;
    logic [1:0] tx_dly, rx_dly;
    logic [6:0] tx_slot, rx_slot;
    logic [4:0] tx_bit, rx_bit;
    logic tx_drv;
    logic [7:0] div_cnt;
    logic clkg, fsg;
    logic [11:0] fr_cnt;
    logic tclk_p, rclk_p, tfs_p, rfs_p, src_p;
    logic tx_clk_o, tx_clk_oe, tx_fs_o, tx_fs_oe;
    logic rx_clk_o, rx_clk_oe, rx_fs_o, rx_fs_oe;
    logic tx_d, tx_d_oe, tx_ev, rx_ev;
  } state_s;
  state_s s;
  state_s n;
  ////////////////////////////////////////////////////////////////////
  // companding, 16-bit linear against 8-bit codes
  function automatic logic [7:0] mu_enc(input logic [15:0] x);
    logic [15:0] m;
    logic [2:0] e;
    m = x[15] ? 16'(-x) : x;
    if (m > MU_CLIP) begin
      m = MU_CLIP;
    end
    m = 16'(m + MU_BIAS);
    e = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (m[i+7]) begin
        e = 3'(i);
      end
    end
    mu_enc = ~{x[15], e, 4'(m >> (5'(e) + 5'h03))};
  endfunction : mu_enc
  function automatic logic [15:0] mu_dec(input logic [7:0] c);
    logic [7:0] u;
    logic [15:0] t;
    u = ~c;
    t = 16'((16'({u[3:0], 3'h0}) + MU_BIAS) << u[6:4]);
    mu_dec = u[7] ? 16'(MU_BIAS - t) : 16'(t - MU_BIAS);
  endfunction : mu_dec
  function automatic logic [7:0] alaw_enc(input logic [15:0] x);
    logic [15:0] m;
    logic [11:0] v;
    logic [2:0] g;
    m = x[15] ? 16'(-x) : x;
    if (m[15]) begin
      m = ALAW_CLIP;
    end
    v = 12'(m >> 3);
    g = 3'h0;
    for (int i = 5; i < 12; i++) begin
      if (v[i]) begin
        g = 3'(i - 4);
      end
    end
    alaw_enc = {~x[15], g, 4'(v >> ((g == 3'h0) ? 3'h1 : g))} ^ ALAW_XOR;
  endfunction : alaw_enc
  function automatic logic [15:0] alaw_dec(input logic [7:0] c);
    logic [7:0] u;
    logic [15:0] t;
    u = c ^ ALAW_XOR;
    t = 16'({u[3:0], 4'h8});
    if (u[6:4] != 3'h0) begin
      t = 16'((t + ALAW_SEG) << (u[6:4] - 3'h1));
    end
    alaw_dec = u[7] ? t : 16'(-t);
  endfunction : alaw_dec
  ////////////////////////////////////////////////////////////////////
  // derived controls
  logic tx_en, rx_en, comp, alaw, cstop, csm, mcx, tx_gpio, rx_gpio;
  logic [2:0] wcode;
  logic [5:0] wl;
  logic [7:0] nw;
  logic [31:0] tx_al, rx_raw, rx_word;
  logic [15:0] rx_lin, pcr_rd;
  logic gate, clk_src, fs_int, tx_cint, tx_fint;
  logic tx_clk_lvl, tx_fs_lvl, rx_clk_lvl, rx_fs_lvl, src_lvl, src_tick;
  logic t_edge, r_edge, tx_start, rx_start, tgo, rgo, ten, ren;
  assign tx_en = s.ctrl[C_TX_EN];
  assign rx_en = s.ctrl[C_RX_EN];
  assign comp = s.ctrl[C_COMP];
  assign alaw = s.ctrl[C_ALAW];
  assign cstop = s.ctrl[C_CSTOP];
  assign csm = s.ctrl[C_CSMASTER];
  assign mcx = s.ctrl[C_MC] & ~cstop;
  assign wcode = s.ctrl[C_WLEN +: 3];
  assign wl = comp ? WL_COMP : (wcode > WL_CODE_MAX) ? WL_FULL : WORD_BITS[wcode];
  assign nw = mcx ? 8'({1'b0, s.ctrl[C_NWORDS +: 7]}) + 8'h01 : 8'h01;
  assign tx_gpio = s.serial_pin_control[PCR_TX_GPIO_ENABLE] & ~tx_en;
  assign rx_gpio = s.serial_pin_control[PCR_RX_GPIO_ENABLE] & ~rx_en;
  // compressed words sit in the low byte; aligned to bit 31 for shifting
  assign tx_al = (comp ? {24'h000000, alaw ? alaw_enc(s.tdr[15:0]) : mu_enc(s.tdr[15:0])}
                       : s.tdr) << (6'h20 - wl);
  assign rx_raw = {s.receive_shift_reg[30:0], I_RX_DATA} & (32'hFFFFFFFF >> (6'h20 - wl));
  assign rx_lin = alaw ? alaw_dec(rx_raw[7:0]) : mu_dec(rx_raw[7:0]);
  assign rx_word = comp ? {{16{rx_lin[15]}}, rx_lin} : rx_raw;
  // clock-stop master runs the clock only while a word is pending
  assign gate = ~cstop | s.tdr_full | (s.tx_ph != PH_IDLE);
  assign clk_src = gate & s.clkg;
  assign fs_int = cstop ? gate : s.fsg;
  assign tx_cint = cstop ? csm : s.serial_pin_control[PCR_TX_CLOCK_MODE];
  assign tx_fint = cstop ? csm : s.serial_pin_control[PCR_TX_FRAME_SYNC_MODE];
  assign tx_clk_lvl = tx_cint ? clk_src : I_TX_CLK ^ s.serial_pin_control[PCR_TX_CLOCK_POLARITY];
  assign tx_fs_lvl = tx_fint ? fs_int : I_TX_FS ^ s.serial_pin_control[PCR_TX_FRAME_SYNC_POLARITY];
  // in clock-stop the receiver follows the transmit clock and select
  assign rx_clk_lvl = cstop ? tx_clk_lvl : s.serial_pin_control[PCR_RX_CLOCK_MODE] ? s.clkg
                      : I_RX_CLK ^ s.serial_pin_control[PCR_RX_CLOCK_POLARITY];
  assign rx_fs_lvl = cstop ? tx_fs_lvl : s.serial_pin_control[PCR_RX_FRAME_SYNC_MODE] ? s.fsg
                     : I_RX_FS ^ s.serial_pin_control[PCR_RX_FRAME_SYNC_POLARITY];
  // transmit drives on rising, receive samples on falling edges
  assign t_edge = tx_clk_lvl & ~s.tclk_p;
  assign r_edge = ~rx_clk_lvl & s.rclk_p;
  assign tx_start = t_edge & tx_fs_lvl & ~s.tfs_p;
  assign rx_start = r_edge & rx_fs_lvl & ~s.rfs_p;
  assign src_lvl = ~s.serial_pin_control[PCR_SAMPLE_CLOCK_EXT_SELECT] ? I_SAMPLE_CLK
                   : s.srg2[S_PINSEL] ? I_TX_CLK : I_RX_CLK;
  assign src_tick = ~s.srg2[S_EXT] | (src_lvl & ~s.src_p);
  always_comb begin
    pcr_rd = s.serial_pin_control & PCR_WMASK;
    if (rx_gpio) begin
      pcr_rd[PCR_SAMPLE_CLOCK_PIN_STATE] = I_SAMPLE_CLK;
      pcr_rd[PCR_RX_DATA_PIN_STATE] = I_RX_DATA;
      if (!s.serial_pin_control[PCR_RX_CLOCK_MODE]) begin
        pcr_rd[PCR_RX_CLOCK_POLARITY] = I_RX_CLK;
      end
      if (!s.serial_pin_control[PCR_RX_FRAME_SYNC_MODE]) begin
        pcr_rd[PCR_RX_FRAME_SYNC_POLARITY] = I_RX_FS;
      end
    end
    if (tx_gpio) begin
      if (!s.serial_pin_control[PCR_TX_CLOCK_MODE]) begin
        pcr_rd[PCR_TX_CLOCK_POLARITY] = I_TX_CLK;
      end
      if (!s.serial_pin_control[PCR_TX_FRAME_SYNC_MODE]) begin
        pcr_rd[PCR_TX_FRAME_SYNC_POLARITY] = I_TX_FS;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  always_comb begin
    n = s;
    tgo = 1'b0;
    rgo = 1'b0;
    ten = 1'b0;
    ren = 1'b0;
    n.tx_ev = 1'b0;
    n.rx_ev = 1'b0;
    n.rdata = 32'h00000000;
    // register reads
    if (I_RD) begin
      case (I_ADDR)
        ADDR_TDR: n.rdata = s.tdr;
        ADDR_RDR: begin
          n.rdata = s.rdr;
          n.rdr_full = 1'b0;
        end
        ADDR_CTRL: n.rdata = 32'(s.ctrl);
        ADDR_PCR: n.rdata = {16'h0000, pcr_rd};
        ADDR_SRG1: n.rdata = {16'h0000, s.srg1};
        ADDR_SRG2: n.rdata = {16'h0000, s.srg2};
        ADDR_STAT: n.rdata = {27'h0000000, s.rbr_full, s.rx_orun, s.tx_urun,
                              s.rdr_full, ~s.tdr_full};
        ADDR_TXMASK: n.rdata = s.txmask;
        ADDR_RXMASK: n.rdata = s.rxmask;
        default: n.rdata = 32'h00000000;
      endcase
    end
    // register writes; data register write comes last
    if (I_WR) begin
      case (I_ADDR)
        ADDR_CTRL: n.ctrl = I_WDATA[CTRL_W-1:0];
        ADDR_PCR: n.serial_pin_control = I_WDATA[15:0] & PCR_WMASK;
        ADDR_SRG1: n.srg1 = I_WDATA[15:0];
        ADDR_SRG2: n.srg2 = I_WDATA[15:0];
        ADDR_STAT: begin
          if (I_WDATA[ST_URUN]) begin
            n.tx_urun = 1'b0;
          end
          if (I_WDATA[ST_ORUN]) begin
            n.rx_orun = 1'b0;
          end
        end
        ADDR_TXMASK: n.txmask = I_WDATA;
        ADDR_RXMASK: n.rxmask = I_WDATA;
        default: n.ctrl = s.ctrl;
      endcase
    end
    //////////////////////////////////////////////////////////////////
    // sample rate generator; one half period is at least one cycle
    n.src_p = src_lvl;
    if (src_tick) begin
      if (s.div_cnt == s.srg1[S_DIV +: 8]) begin
        n.div_cnt = 8'h00;
        n.clkg = ~s.clkg;
        if (!s.clkg) begin
          n.fr_cnt = (s.fr_cnt == s.srg2[S_FPER +: 12]) ? 12'h000 : s.fr_cnt + 12'h001;
          n.fsg = n.fr_cnt < {4'h0, s.srg1[S_FWID +: 8]};
        end
      end else begin
        n.div_cnt = s.div_cnt + 8'h01;
      end
    end
    //////////////////////////////////////////////////////////////////
    // transmitter
    n.tclk_p = tx_clk_lvl;
    if (!tx_en) begin
      n.tx_ph = PH_IDLE;
      n.tdr_full = 1'b0;
      n.tx_urun = 1'b0;
    end else if (t_edge) begin
      n.tfs_p = tx_fs_lvl;
      if (tx_start) begin
        n.tx_slot = 7'h00;
        n.tx_bit = 5'h00;
        n.tx_dly = s.ctrl[C_FDLY +: 2];
        n.tx_ph = (n.tx_dly == 2'h0) ? PH_SHIFT : PH_DELAY;
        tgo = (n.tx_dly == 2'h0);
      end else if (s.tx_ph == PH_DELAY) begin
        n.tx_dly = s.tx_dly - 2'h1;
        tgo = (s.tx_dly == 2'h1);
      end else begin
        tgo = (s.tx_ph == PH_SHIFT);
      end
    end
    if (tgo) begin
      n.tx_ph = PH_SHIFT;
      if (n.tx_bit == 5'h00) begin
        ten = ~mcx | ((n.tx_slot[6:5] == 2'h0) & s.txmask[n.tx_slot[4:0]]);
        n.tx_drv = ten;
        n.tx_d = tx_al[31];
        n.tsr = {tx_al[30:0], 1'b0};
        if (ten) begin
          n.tdr_full = 1'b0;
          n.tx_urun = n.tx_urun | ~s.tdr_full;
          n.tx_ev = 1'b1;
        end
      end else begin
        n.tx_d = s.tsr[31];
        n.tsr = {s.tsr[30:0], 1'b0};
      end
      if (n.tx_bit == 5'(wl - 6'h01)) begin
        n.tx_bit = 5'h00;
        if ({1'b0, n.tx_slot} == nw - 8'h01) begin
          n.tx_ph = PH_IDLE;
        end else begin
          n.tx_slot = n.tx_slot + 7'h01;
        end
      end else begin
        n.tx_bit = n.tx_bit + 5'h01;
      end
    end
    //////////////////////////////////////////////////////////////////
    // receiver
    n.rclk_p = rx_clk_lvl;
    if (!rx_en) begin
      n.rx_ph = PH_IDLE;
      n.rbr_full = 1'b0;
      n.rdr_full = 1'b0;
      n.rx_orun = 1'b0;
    end else if (r_edge) begin
      n.rfs_p = rx_fs_lvl;
      if (rx_start) begin
        n.rx_slot = 7'h00;
        n.rx_bit = 5'h00;
        n.rx_dly = s.ctrl[C_FDLY +: 2];
        n.rx_ph = (n.rx_dly == 2'h0) ? PH_SHIFT : PH_DELAY;
        rgo = (n.rx_dly == 2'h0);
      end else if (s.rx_ph == PH_DELAY) begin
        n.rx_dly = s.rx_dly - 2'h1;
        rgo = (s.rx_dly == 2'h1);
      end else begin
        rgo = (s.rx_ph == PH_SHIFT);
      end
    end
    if (rgo) begin
      n.rx_ph = PH_SHIFT;
      n.receive_shift_reg = {s.receive_shift_reg[30:0], I_RX_DATA};
      if (n.rx_bit == 5'(wl - 6'h01)) begin
        ren = ~mcx | ((n.rx_slot[6:5] == 2'h0) & s.rxmask[n.rx_slot[4:0]]);
        if (ren) begin
          // a full buffer keeps its word; the new one is lost
          if (s.rbr_full) begin
            n.rx_orun = 1'b1;
          end else begin
            n.receive_buffer_reg = rx_word;
            n.rbr_full = 1'b1;
          end
        end
        n.rx_bit = 5'h00;
        if ({1'b0, n.rx_slot} == nw - 8'h01) begin
          n.rx_ph = PH_IDLE;
        end else begin
          n.rx_slot = n.rx_slot + 7'h01;
        end
      end else begin
        n.rx_bit = n.rx_bit + 5'h01;
      end
    end
    if (n.rbr_full && !n.rdr_full) begin
      n.rdr = n.receive_buffer_reg;
      n.rdr_full = 1'b1;
      n.rbr_full = 1'b0;
      n.rx_ev = 1'b1;
    end
    // a write in the load cycle is kept: the shifter took the old word
    if (I_WR && I_ADDR == ADDR_TDR) begin
      n.tdr = I_WDATA;
      n.tdr_full = tx_en;
    end
    //////////////////////////////////////////////////////////////////
    // pins; general-purpose mode drives the state bits instead
    n.tx_clk_o = tx_gpio ? s.serial_pin_control[PCR_TX_CLOCK_POLARITY]
                 : clk_src ^ s.serial_pin_control[PCR_TX_CLOCK_POLARITY];
    n.tx_clk_oe = tx_gpio ? s.serial_pin_control[PCR_TX_CLOCK_MODE] : tx_cint;
    n.tx_fs_o = tx_gpio ? s.serial_pin_control[PCR_TX_FRAME_SYNC_POLARITY]
                : fs_int ^ s.serial_pin_control[PCR_TX_FRAME_SYNC_POLARITY];
    n.tx_fs_oe = tx_gpio ? s.serial_pin_control[PCR_TX_FRAME_SYNC_MODE] : tx_fint;
    n.tx_d_oe = tx_gpio | (tx_en & n.tx_drv
                & ((n.tx_ph != PH_IDLE) | tgo | (s.tx_d_oe & ~t_edge)));
    if (tx_gpio) begin
      n.tx_d = s.serial_pin_control[PCR_TX_DATA_PIN_STATE];
    end
    n.rx_clk_o = rx_gpio ? s.serial_pin_control[PCR_RX_CLOCK_POLARITY]
                 : s.clkg ^ s.serial_pin_control[PCR_RX_CLOCK_POLARITY];
    n.rx_clk_oe = s.serial_pin_control[PCR_RX_CLOCK_MODE] & (rx_gpio | ~cstop);
    n.rx_fs_o = rx_gpio ? s.serial_pin_control[PCR_RX_FRAME_SYNC_POLARITY]
                : s.fsg ^ s.serial_pin_control[PCR_RX_FRAME_SYNC_POLARITY];
    n.rx_fs_oe = s.serial_pin_control[PCR_RX_FRAME_SYNC_MODE] & (rx_gpio | ~cstop);
  end
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.serial_pin_control <= PCR_RST;
    end else begin
      s <= n;
    end
  end
  ////////////////////////////////////////////////////////////////////
  assign O_RDATA = s.rdata;
  assign O_TX_CLK = s.tx_clk_o;
  assign O_TX_CLK_OE = s.tx_clk_oe;
  assign O_TX_FS = s.tx_fs_o;
  assign O_TX_FS_OE = s.tx_fs_oe;
  assign O_TX_DATA = s.tx_d;
  assign O_TX_DATA_OE = s.tx_d_oe;
  assign O_RX_CLK = s.rx_clk_o;
  assign O_RX_CLK_OE = s.rx_clk_oe;
  assign O_RX_FS = s.rx_fs_o;
  assign O_RX_FS_OE = s.rx_fs_oe;
  assign O_TX_EVENT = s.tx_ev;
  assign O_RX_EVENT = s.rx_ev;
endmodule : serial_port
`default_nettype wire

// file: verification/serial_port_assertions.sv
// port-level checker for serial_port, bound to every instance
// assumes register writes land at the strobe edge, outputs one cycle later
`timescale 1ns/100ps
`default_nettype none
module serial_port_assertions
  import serial_port_pkg::*;
(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  // register port
  input wire logic [3:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [31:0] O_RDATA,
  // pins and events
  input wire logic O_TX_DATA,
  input wire logic O_TX_DATA_OE,
  input wire logic I_RX_DATA,
  input wire logic I_SAMPLE_CLK,
  input wire logic O_TX_EVENT,
  input wire logic O_RX_EVENT
);
  // shadow of pin control and enables, rebuilt from the writes
  logic [15:0] pcr_r;
  logic [1:0] en_r;
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      pcr_r <= 16'h0000;
      en_r <= 2'h0;
    end else if (I_WR && I_ADDR == ADDR_PCR) begin
      pcr_r <= I_WDATA[15:0] & PCR_WMASK;
    end else if (I_WR && I_ADDR == ADDR_CTRL) begin
      en_r <= I_WDATA[1:0];
    end
  end
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  ////////////////////////////////
  a_rdata_quiet: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
    else $error("read data not zero outside read slot");
  a_pcr_reserved: assert property (
    $past(I_RD) && $past(I_ADDR) == ADDR_PCR |-> O_RDATA[31:14] == 18'h0)
    else $error("pin control reserved bits not zero");
  a_unmapped_zero: assert property (
    $past(I_RD) && $past(I_ADDR) > ADDR_RXMASK |-> O_RDATA == 32'h0)
    else $error("unmapped read not zero");
  // a word is at least 8 bits of at least 2 cycles each
  a_tx_event_gap: assert property (O_TX_EVENT |=> !O_TX_EVENT [*8])
    else $error("transmit events too close");
  a_rx_event_gap: assert property (O_RX_EVENT |=> !O_RX_EVENT [*8])
    else $error("receive events too close");
  a_rx_event_enabled: assert property (O_RX_EVENT |-> en_r[1])
    else $error("receive event while receiver in reset");
  a_tx_gpio_pin: assert property (
    pcr_r[13] && !en_r[0] && $stable(pcr_r) && $stable(en_r)
    |=> O_TX_DATA_OE && O_TX_DATA == $past(pcr_r[5]))
    else $error("transmit data pin not driven from pin state");
  a_tx_quiet: assert property (
    !pcr_r[13] && !en_r[0] && $stable(en_r) |=> !O_TX_DATA_OE)
    else $error("transmit data driven while idle");
  a_rx_gpio_read: assert property (
    I_RD && I_ADDR == ADDR_PCR && pcr_r[12] && !en_r[1]
    |=> O_RDATA[6] == $past(I_SAMPLE_CLK) && O_RDATA[4] == $past(I_RX_DATA))
    else $error("receive pin levels not read back");
endmodule : serial_port_assertions
bind serial_port serial_port_assertions u_chk (.I_CLK_SYS, .I_RST_N, .I_ADDR, .I_WDATA,
  .I_WR, .I_RD, .O_RDATA, .O_TX_DATA, .O_TX_DATA_OE, .I_RX_DATA, .I_SAMPLE_CLK,
  .O_TX_EVENT, .O_RX_EVENT);
`default_nettype wire

// file: verification/serial_link_partner.sv
// codec-like far end: clocks both links, sends and captures 16-bit frames
// assumes external clock and frame modes, no frame delay
`timescale 1ns/100ps
`default_nettype none
module serial_link_partner (
  // system side
  input wire logic i_clk,
  input wire logic [7:0] i_count,
  // link pins
  output logic o_bclk,
  output logic o_fs,
  output logic o_data,
  input wire logic i_data,
  // capture
  output logic [15:0] o_word,
  output logic [7:0] o_frames
);
  logic [15:0] sh_r;
  logic [15:0] rx_w;
  int b;
  ////////////////////////////////
  // clock runs frame after frame and stands still once i_count frames are sent
  initial begin
    {o_bclk, o_fs, o_data, o_word, o_frames} = '0;
    forever begin
      @(posedge i_clk);
      if (o_frames < i_count) begin
        rx_w = 16'hA500 | {8'h00, o_frames};
        for (b = 15; b >= 0; b--) begin
          o_bclk <= 1'b1;
          o_fs <= (b == 15);
          o_data <= rx_w[b];
          repeat (5) @(posedge i_clk);
          o_bclk <= 1'b0;
          sh_r = {sh_r[14:0], i_data};
          repeat (5) @(posedge i_clk);
        end
        o_word <= sh_r;
        o_frames <= o_frames + 8'h01;
        o_data <= ~rx_w[0]; // released line must not look held
      end
    end
  end
endmodule : serial_link_partner
`default_nettype wire

// file: verification/multichannel_buffered_serial_port_test.sv
// self-checking bench for serial_port with a codec partner on both links
// assumes one shared external bit clock and frame sync for both links
`timescale 1ns/100ps
`default_nettype none
module multichannel_buffered_serial_port_test;
  import serial_port_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sclk = 1'b0;
  logic [7:0] nfr = 8'h00;
  logic [31:0] rdata, d;
  logic bclk, fs, rxd, txd, txd_oe, tclk_o, tclk_oe, rfs_o, rfs_oe, tx_ev;
  logic tfs_o, tfs_oe, rclk_o, rclk_oe, rx_ev;
  logic [15:0] cap;
  logic [7:0] frames;
  int n_errors = 0;
  int check_count = 0;
  // shared pins resolve to whoever drives them
  wire tclk_pin = tclk_oe ? tclk_o : bclk;
  wire rfs_pin = rfs_oe ? rfs_o : fs;
  always #50 clk = ~clk;
  serial_port uut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TX_CLK(tclk_pin), .O_TX_CLK(tclk_o),
    .O_TX_CLK_OE(tclk_oe), .I_TX_FS(fs), .O_TX_FS(tfs_o), .O_TX_FS_OE(tfs_oe), .O_TX_DATA(txd),
    .O_TX_DATA_OE(txd_oe), .I_RX_CLK(bclk), .O_RX_CLK(rclk_o), .O_RX_CLK_OE(rclk_oe),
    .I_RX_FS(rfs_pin), .O_RX_FS(rfs_o), .O_RX_FS_OE(rfs_oe), .I_RX_DATA(rxd), .I_SAMPLE_CLK(sclk),
    .O_TX_EVENT(tx_ev), .O_RX_EVENT(rx_ev));
  serial_link_partner far_end (.i_clk(clk), .i_count(nfr), .o_bclk(bclk), .o_fs(fs),
    .o_data(rxd), .i_data(txd), .o_word(cap), .o_frames(frames));
  ////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask : rd_reg
  // bounded wait: a lost frame shows as a failed compare, not a hang
  task automatic wait_frame(input logic [7:0] n, input logic [15:0] exp);
    repeat (400) begin
      @(posedge clk);
      if (frames === n) break;
    end
    chk({24'h0, frames}, {24'h0, n});
    chk({16'h0, cap}, {16'h0, exp});
  endtask : wait_frame
  ////////////////////////////////
  task automatic t_pcr();
    rd_reg(ADDR_PCR, d);
    chk(d, 32'h0000_0000);
    wr_reg(ADDR_PCR, 32'hFFFF_CFFF);
    rd_reg(ADDR_PCR, d);
    chk(d, 32'h0000_0FFF);
    chk({28'h0, tclk_oe, rfs_oe, tfs_oe, rclk_oe}, 32'hF);
    wr_reg(ADDR_PCR, 32'h0);
  endtask : t_pcr
  task automatic t_gpio();
    wr_reg(ADDR_PCR, 32'h0000_3F3F);
    sclk <= 1'b1;
    repeat (3) @(posedge clk);
    chk({26'h0, txd_oe, txd, tclk_oe, tclk_o, tfs_oe, tfs_o}, 32'h3F);
    chk({28'h0, rclk_oe, rclk_o, rfs_oe, rfs_o}, 32'hF);
    rd_reg(ADDR_PCR, d);
    chk({30'h0, d[6], d[4]}, {30'h0, 1'b1, rxd});
    wr_reg(ADDR_PCR, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, txd_oe}, 32'h0);
    rd_reg(4'hF, d);
    chk(d, 32'h0);
  endtask : t_gpio
  // three frames, one late write, nothing read until the end
  task automatic t_link();
    wr_reg(ADDR_CTRL, 32'h0000_000B);
    wr_reg(ADDR_TDR, 32'h0000_C35A);
    nfr <= 8'h03;
    repeat (400) begin
      @(posedge clk);
      if (tx_ev === 1'b1) break;
    end
    chk({31'h0, tx_ev}, 32'h1);
    wr_reg(ADDR_TDR, 32'h0000_5AC3);
    wait_frame(8'h01, 16'hC35A);
    wait_frame(8'h02, 16'h5AC3);
    wait_frame(8'h03, 16'h5AC3);
    repeat (4) @(posedge clk);
    rd_reg(ADDR_STAT, d);
    chk(d, 32'h0000_001F);
    rd_reg(ADDR_RDR, d);
    chk(d, 32'h0000_A500);
    chk({31'h0, rx_ev}, 32'h1);
    repeat (2) @(posedge clk);
    rd_reg(ADDR_RDR, d);
    chk(d, 32'h0000_A501);
    chk({31'h0, rx_ev}, 32'h0);
  endtask : t_link
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_pcr();
    t_gpio();
    t_link();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end
endmodule : multichannel_buffered_serial_port_test
`default_nettype wire
